// ---- pkg/harvest_pkg.sv ----
// Constants, types and helpers shared by the harvest register block
package harvest_pkg;

  localparam int BYTE_W = 8;
  localparam int CNT_W = 16;
  localparam int TICK_W = 9;

  // Register offsets
  localparam logic [7:0] ADDR_OC_RESULT = 8'h09;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h0A;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h0B;
  localparam logic [7:0] ADDR_SLEEP_THD = 8'h0C;

  // Reset values, counter saturation and step
  localparam logic [7:0] OC_RESULT_RESET = 8'h1D;
  localparam logic [7:0] SLEEP_THD_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_SATURATED = 16'hFFFF;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Automatic measurement period codes
  localparam logic [1:0] PERIOD_64 = 2'b00;
  localparam logic [1:0] PERIOD_128 = 2'b01;
  localparam logic [1:0] PERIOD_256 = 2'b10;
  localparam logic [1:0] PERIOD_OFF = 2'b11;
  localparam logic [8:0] TICKS_64 = 9'h040;
  localparam logic [8:0] TICKS_128 = 9'h080;
  localparam logic [8:0] TICKS_256 = 9'h100;
  localparam logic [8:0] TICK_STEP = 9'h001;
  localparam logic [8:0] TICK_ZERO = 9'h000;

  // Register port request from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_BUSY = 2'b10
  } meas_state_t;

  // Last tick index of one automatic period
  function automatic logic [8:0] period_last(input logic [1:0] code);
    logic [8:0] n;
    n = TICKS_64;
    case (code)
      PERIOD_64: n = TICKS_64;
      PERIOD_128: n = TICKS_128;
      PERIOD_256: n = TICKS_256;
      default: n = TICKS_64;
    endcase
    return n - TICK_STEP;
  endfunction

endpackage

// ---- design/pulse_counter.sv ----
// Saturating counter of boost switch-node pulses
`timescale 1ns/1ps
`default_nettype none
module pulse_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic pulse_i,
  input wire logic freeze_i,
  // Result
  output logic [WIDTH-1:0] count_o,
  output logic update_o
);
  import harvest_pkg::*;

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic update_r;
  logic update_nxt;

  always_comb
  begin
    count_nxt = count_r;
    update_nxt = 1'b0;
    if (pulse_i && !freeze_i)
    begin
      update_nxt = 1'b1;
      if (count_r != WIDTH'(CNT_SATURATED))
      begin
        count_nxt = count_r + WIDTH'(CNT_STEP);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_r <= WIDTH'(CNT_RESET);
      update_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      update_r <= update_nxt;
    end
  end

  assign count_o = count_r;
  assign update_o = update_r;

  saturate_hold_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    count_r == WIDTH'(CNT_SATURATED) |=> count_r == WIDTH'(CNT_SATURATED))
  else $error("pulse counter wrapped after saturation");

  freeze_hold_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    freeze_i |=> $stable(count_r))
  else $error("pulse counter moved while frozen");

endmodule
`default_nettype wire

// ---- design/harvest_measure_sleep_regs.sv ----
// Open-circuit result, pulse count and sleep control registers
//
// Behaviour
// - Hold latest 8-bit open-circuit result code.
// - Reading result has no side effect.
// - Host write replaces measured result value.
// - Result below default halts boost, sleeps.
// - Measured or written result not below default ends result sleep.
// - High count byte readable, read only.
// - Low count byte readable, read only.
// - Count valid only above wake threshold.
// - Counter saturates at all ones.
// - Counter frozen while sleeping.
// - Count threshold forces sleep until measurement.
// - Zero threshold disables count sleep.
// - Threshold readable, compares the high count byte.
// - Force bit starts measurement, self-clears.
// - Period codes give 64/128/256 or off.
`timescale 1ns/1ps
`default_nettype none
module harvest_measure_sleep_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire harvest_pkg::reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Measurement control
  input wire logic force_measure_i,
  input wire logic [1:0] period_code_i,
  input wire logic meas_time_tick_i,
  input wire logic measure_done_i,
  input wire logic [7:0] measure_code_i,
  output logic measure_start_o,
  output logic force_pending_o,
  // Converter pins
  input wire logic switch_node_i,
  input wire logic system_above_wake_i,
  output logic sleep_o,
  output logic count_valid_o
);
  import harvest_pkg::*;

  meas_state_t state_r;
  meas_state_t state_nxt;
  logic [8:0] tick_cnt_r;
  logic [8:0] tick_cnt_nxt;
  logic force_pend_r;
  logic force_pend_nxt;
  logic auto_pend_r;
  logic auto_pend_nxt;
  logic start_r;
  logic start_nxt;
  logic auto_fire;
  logic [7:0] oc_result_r;
  logic [7:0] oc_result_nxt;
  logic [7:0] thd_r;
  logic [7:0] thd_nxt;
  logic low_sleep_r;
  logic low_sleep_nxt;
  logic count_sleep_r;
  logic count_sleep_nxt;
  logic sleep_r;
  logic sleep_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic [2:0] sw_sync_r;
  logic [1:0] wake_sync_r;
  logic valid_r;
  logic meas_done;
  logic res_write;
  logic [15:0] count;
  logic count_upd;

  // Only the second stage feeds logic; third stage is the edge memory
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sw_sync_r <= 3'h0;
      wake_sync_r <= 2'h0;
    end
    else
    begin
      sw_sync_r <= {sw_sync_r[1:0], switch_node_i};
      wake_sync_r <= {wake_sync_r[0], system_above_wake_i};
    end
  end

  pulse_counter #(
    .WIDTH(CNT_W)
  ) u_count (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pulse_i(sw_sync_r[1] && !sw_sync_r[2]),
    .freeze_i(sleep_r),
    .count_o(count),
    .update_o(count_upd)
  );

  assign meas_done = (state_r == MS_BUSY) && measure_done_i;
  assign res_write = reg_req_i.wr && (reg_req_i.addr == ADDR_OC_RESULT);

  // Measurement sequencing
  always_comb
  begin
    state_nxt = state_r;
    tick_cnt_nxt = tick_cnt_r;
    auto_fire = 1'b0;
    start_nxt = 1'b0;
    // period count, code 11 stops it
    if (period_code_i == PERIOD_OFF)
    begin
      tick_cnt_nxt = TICK_ZERO;
    end
    else if (meas_time_tick_i)
    begin
      if (tick_cnt_r >= period_last(period_code_i))
      begin
        tick_cnt_nxt = TICK_ZERO;
        auto_fire = 1'b1;
      end
      else
      begin
        tick_cnt_nxt = tick_cnt_r + TICK_STEP;
      end
    end
    case (state_r)
      MS_IDLE:
      begin
        if (force_pend_r || auto_pend_r)
        begin
          start_nxt = 1'b1;
          state_nxt = MS_BUSY;
        end
      end
      MS_BUSY:
      begin
        if (measure_done_i)
        begin
          state_nxt = MS_IDLE;
        end
      end
      default: state_nxt = MS_IDLE;
    endcase
    // force request clears itself at start; a new request wins
    force_pend_nxt = force_measure_i || (force_pend_r && !start_nxt);
    auto_pend_nxt = auto_fire || (auto_pend_r && !start_nxt);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= MS_IDLE;
      tick_cnt_r <= TICK_ZERO;
      force_pend_r <= 1'b0;
      auto_pend_r <= 1'b0;
      start_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      force_pend_r <= force_pend_nxt;
      auto_pend_r <= auto_pend_nxt;
      start_r <= start_nxt;
    end
  end

  // Result, threshold and sleep state
  always_comb
  begin
    oc_result_nxt = oc_result_r;
    thd_nxt = thd_r;
    low_sleep_nxt = low_sleep_r;
    count_sleep_nxt = count_sleep_r;
    // measured code stored; measurement beats a colliding write
    if (meas_done)
    begin
      oc_result_nxt = measure_code_i;
    end
    // collision with a pending measurement left to the host
    else if (res_write)
    begin
      oc_result_nxt = reg_req_i.wdata;
    end
    // written or measured result not below default ends low sleep
    if (meas_done || res_write)
    begin
      low_sleep_nxt = (oc_result_nxt < OC_RESULT_RESET);
    end
    if (reg_req_i.wr && (reg_req_i.addr == ADDR_SLEEP_THD))
    begin
      thd_nxt = reg_req_i.wdata;
    end
    // count sleep lasts until next measurement
    if (meas_done)
    begin
      count_sleep_nxt = 1'b0;
    end
    // upper byte below threshold at update
    else if (count_upd && !sleep_r && (thd_r != SLEEP_THD_RESET) &&
             (count[15:8] < thd_r))
    begin
      count_sleep_nxt = 1'b1;
    end
    sleep_nxt = low_sleep_nxt || count_sleep_nxt;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      oc_result_r <= OC_RESULT_RESET;
      thd_r <= SLEEP_THD_RESET;
      low_sleep_r <= 1'b0;
      count_sleep_r <= 1'b0;
      sleep_r <= 1'b0;
    end
    else
    begin
      oc_result_r <= oc_result_nxt;
      thd_r <= thd_nxt;
      low_sleep_r <= low_sleep_nxt;
      count_sleep_r <= count_sleep_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  // Read path; reads change nothing but the read data and read valid
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_req_i.rd)
    begin
      // count bytes have no write path
      case (reg_req_i.addr)
        ADDR_OC_RESULT: rdata_nxt = oc_result_r;
        ADDR_CNT_HIGH: rdata_nxt = count[15:8];
        ADDR_CNT_LOW: rdata_nxt = count[7:0];
        ADDR_SLEEP_THD: rdata_nxt = thd_r;
        default: rdata_nxt = RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r <= RDATA_UNMAPPED;
      rvalid_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= reg_req_i.rd;
      // count flagged valid above wake threshold only
      valid_r <= wake_sync_r[1] && !sleep_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign measure_start_o = start_r;
  assign force_pending_o = force_pend_r;
  assign sleep_o = sleep_r;
  assign count_valid_o = valid_r;

  read_no_effect_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_req_i.rd && !reg_req_i.wr && !meas_done && !force_measure_i &&
    !force_pend_r && !auto_pend_r |=> $stable(oc_result_r) && !start_r && !force_pend_r)
  else $error("result read disturbed state");

  write_override_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    res_write && !meas_done |=> oc_result_r == $past(reg_req_i.wdata))
  else $error("host write did not replace result");

  low_sleep_entry_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    meas_done && (measure_code_i < OC_RESULT_RESET) |=> sleep_r && sleep_o)
  else $error("low result did not enter sleep");

  sleep_exit_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    meas_done && (measure_code_i >= OC_RESULT_RESET) |=> !sleep_r)
  else $error("measurement did not end sleep");

  count_byte_read_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_req_i.rd && reg_req_i.addr == ADDR_CNT_HIGH |=> reg_rdata_o == $past(count[15:8]))
  else $error("high count byte read wrong");

  count_sleep_entry_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    count_upd && !sleep_r && thd_r != SLEEP_THD_RESET && count[15:8] < thd_r && !meas_done
    |=> count_sleep_r && sleep_r)
  else $error("count threshold did not enter sleep");

  zero_thd_off_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    thd_r == SLEEP_THD_RESET && !count_sleep_r |=> !count_sleep_r)
  else $error("count sleep with zero threshold");

  force_start_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    force_measure_i && state_r == MS_IDLE |-> ##[1:2] measure_start_o)
  else $error("forced measurement did not start");

  period_off_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    period_code_i == PERIOD_OFF && !force_pend_r && !auto_pend_r |=> !measure_start_o)
  else $error("automatic measurement while disabled");

endmodule
`default_nettype wire

// ---- verif/meas_model.sv ----
// Behavioural measurement engine answering measurement starts
`timescale 1ns/1ps
`default_nettype none
module meas_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Measurement handshake
  input wire logic start_i,
  input wire logic [7:0] code_i,
  output logic done_o,
  output logic [7:0] code_o
);
  logic busy_r;
  logic [2:0] wait_r;
  // Random latency, prompt or slow; code wobbles while not valid
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      busy_r <= 1'b0;
      wait_r <= 3'h0;
      done_o <= 1'b0;
      code_o <= 8'h00;
    end
    else
    begin
      done_o <= 1'b0;
      code_o <= ~code_o;
      if (start_i)
      begin
        busy_r <= 1'b1;
        wait_r <= 3'($urandom_range(0, 5));
      end
      else if (busy_r && wait_r == 3'h0)
      begin
        busy_r <= 1'b0;
        done_o <= 1'b1;
        code_o <= code_i;
      end
      else if (busy_r)
      begin
        wait_r <= wait_r - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_harvest_measure_sleep_regs.sv ----
// Self-checking bench for the harvest register block
`timescale 1ns/1ps
`default_nettype none
module tb_harvest_measure_sleep_regs;
  import harvest_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  reg_req_t req = '0;
  logic frc = 1'b0;
  logic tick = 1'b0;
  logic sw = 1'b0;
  logic wake = 1'b1;
  logic [1:0] per = PERIOD_OFF;
  logic [7:0] nxt_code = 8'h40;
  logic [7:0] mcode, rdata;
  logic done, rvalid, start, pend, slp, cval;
  int error_cnt = 0;
  int checks_done = 0;
  int starts = 0;
  int s0;
  logic [7:0] tbl [4] = '{8'h1C, 8'h1D, 8'h00, 8'hFF};

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (start === 1'b1) starts++;

  harvest_measure_sleep_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .force_measure_i(frc), .period_code_i(per), .meas_time_tick_i(tick),
    .measure_done_i(done), .measure_code_i(mcode), .measure_start_o(start),
    .force_pending_o(pend), .switch_node_i(sw), .system_above_wake_i(wake),
    .sleep_o(slp), .count_valid_o(cval));
  meas_model u_meas (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start),
    .code_i(nxt_code), .done_o(done), .code_o(mcode));

  function automatic logic exp_slp(input logic [7:0] c);
    return c < OC_RESULT_RESET;
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk_i);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    req <= '0;
    #1;
    chk("rvalid", rvalid, 1'b1);
    chk(n, rdata, e);
  endtask

  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      sw <= 1'b1;
      repeat (3) @(posedge clk_i);
      sw <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    #1;
  endtask

  task automatic tk();
    @(posedge clk_i);
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
  endtask

  task automatic wait_done();
    int i;
    for (i = 0; i < 40 && done !== 1'b1; i++)
      @(posedge clk_i);
    if (i == 40)
    begin
      chk("measure done", done, 1'b1);
      stop_test();
    end
    else
    begin
      cyc(2);
    end
  endtask

  // Forced measurement, no result write while pending
  task automatic meas(input logic [7:0] c);
    nxt_code = c;
    s0 = starts;
    @(posedge clk_i);
    frc <= 1'b1;
    @(posedge clk_i);
    frc <= 1'b0;
    #1;
    chk("pending", pend, 1'b1);
    wait_done();
    chk("starts", starts, s0 + 1);
    chk("sleep", slp, exp_slp(c));
    rd(ADDR_OC_RESULT, c, "result");
  endtask

  initial
  begin
    void'($urandom(69));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(2);
    rd(ADDR_OC_RESULT, OC_RESULT_RESET, "result");
    rd(ADDR_CNT_HIGH, 8'h00, "cnt_hi");
    rd(ADDR_CNT_LOW, 8'h00, "cnt_lo");
    rd(ADDR_SLEEP_THD, SLEEP_THD_RESET, "thd");
    rd(8'h3F, RDATA_UNMAPPED, "unmapped");
    chk("sleep", slp, 1'b0);
    $display("test reset done");
    wr(ADDR_OC_RESULT, 8'h1C);
    cyc(1);
    chk("sleep", slp, 1'b1);
    rd(ADDR_OC_RESULT, 8'h1C, "result");
    rd(ADDR_OC_RESULT, 8'h1C, "result");
    chk("starts", starts, 0);
    wr(ADDR_OC_RESULT, 8'h1D);
    cyc(1);
    chk("sleep", slp, 1'b0);
    $display("test result write done");
    pulse(5);
    rd(ADDR_CNT_LOW, 8'h05, "cnt_lo");
    rd(ADDR_CNT_HIGH, 8'h00, "cnt_hi");
    wr(ADDR_CNT_HIGH, 8'hFF);
    wr(ADDR_CNT_LOW, 8'hFF);
    rd(ADDR_CNT_LOW, 8'h05, "cnt_lo");
    wr(ADDR_OC_RESULT, 8'h05);
    pulse(3);
    rd(ADDR_CNT_LOW, 8'h05, "cnt_lo");
    wr(ADDR_OC_RESULT, 8'h40);
    cyc(1);
    chk("sleep", slp, 1'b0);
    $display("test count done");
    wr(ADDR_SLEEP_THD, 8'h01);
    rd(ADDR_SLEEP_THD, 8'h01, "thd");
    pulse(1);
    chk("sleep", slp, 1'b1);
    pulse(2);
    rd(ADDR_CNT_LOW, 8'h06, "cnt_lo");
    meas(8'h40);
    chk("sleep", slp, 1'b0);
    wr(ADDR_SLEEP_THD, 8'h00);
    pulse(2);
    chk("sleep", slp, 1'b0);
    rd(ADDR_CNT_LOW, 8'h08, "cnt_lo");
    $display("test threshold done");
    foreach (tbl[i]) meas(tbl[i]);
    repeat (8) meas(8'($urandom_range(0, 255)));
    meas(8'h40);
    $display("test measure done");
    for (int c = 0; c < 3; c++)
    begin
      per <= PERIOD_OFF;
      cyc(2);
      per <= 2'(c);
      s0 = starts;
      repeat ((64 << c) - 1) tk();
      chk("period early", starts, s0);
      tk();
      cyc(3);
      chk("period start", starts, s0 + 1);
      wait_done();
    end
    per <= PERIOD_OFF;
    s0 = starts;
    repeat (256) tk();
    cyc(4);
    chk("period off", starts, s0);
    $display("test period done");
    chk("count valid", cval, 1'b1);
    wake <= 1'b0;
    cyc(4);
    chk("count valid", cval, 1'b0);
    $display("test wake done");
    stop_test();
  end
endmodule
`default_nettype wire
